// file: hdl/cbc_decoder.sv
// Behaviour
// RULE_01 - status 000 ack, 001 io read, 010 io write plus early io write, 011 none
// RULE_02 - 100 and 101 memory read, 110 memory write plus early write, 111 none
// RULE_03 - strap high: io commands and ack enabled regardless of bus grant
// RULE_04 - strap high: io command at once, peripheral enable and direction steer
// RULE_05 - strap high: memory commands wait for bus grant low
// RULE_06 - strap low: no command until 115 ns after grant goes low
// RULE_07 - strap low: memory and io both wait; arbiter signals free bus
// RULE_08 - early write commands assert before the ordinary write commands
// RULE_09 - interrupt acknowledge is timed like an io read
// RULE_10 - data enable connects buses; direction selects transfer way
// RULE_11 - dual output: peripheral enable in io-bus mode, cascade otherwise
// RULE_12 - strap low: interrupt sequence is two back to back ack cycles
// RULE_13 - outside logic masks cascade enable during the first ack cycle
// RULE_14 - cascade enable asserts just before the ack cycle, with the strobe
// RULE_15 - address latch strobe pulses once in every machine cycle
// RULE_16 - qualifier low forces every command inactive, never high impedance
// RULE_17 - idle processor holds status all ones; other code starts a cycle
// RULE_18 - grant inactive floats command drivers, except io in io-bus mode
// RULE_19 - commands active low, enables high, peripheral enable low, write high
// RULE_20 - timing from one clock; command released on return to all ones
`timescale 1ns/100ps
`default_nettype none
`include "cbc_regs.svh"

module cbc_decoder
   import cbc_pkg::*;
#(
   parameter int unsigned GRANT_DLY_CYC = `CBC_GRANT_DLY_CYC,
   parameter int unsigned GRANT_CNT_W   = 4
) (
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic clk_en,
   input  wire logic status_bit0_n,
   input  wire logic status_bit1_n,
   input  wire logic status_bit2_n,
   input  wire logic bus_grant_n,
   input  wire logic command_qualifier,
   input  wire logic io_bus_strap,
   output logic      mem_read_cmd_n,
   output logic      mem_write_cmd_n,
   output logic      io_read_cmd_n,
   output logic      io_write_cmd_n,
   output logic      early_mem_write_cmd_n,
   output logic      early_io_write_cmd_n,
   output logic      irq_ack_cmd_n,
   output logic      mem_cmd_oe_n,
   output logic      io_cmd_oe_n,
   output logic      address_latch_strobe,
   output logic      data_enable,
   output logic      transfer_direction,
   output logic      cascade_gate_dual
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   logic [2:0]    status;
   logic          passive;
   logic          start;
   logic          grant_ok;
   logic          io_kind;
   logic          allowed;
   logic          cmd_on;
   cbc_kind_type  kind_r;
   cbc_phase_type phase_r;
   cbc_phase_type phase_nxt;
   cbc_cmd_type   cmd_r;
   cbc_cmd_type   cmd_nxt;
   logic          mem_oe_n_r;
   logic          io_oe_n_r;
   logic          ale_r;
   logic          de_r;
   logic          dir_r;
   logic          dual_r;
   logic          dual_nxt;

   // map a status code onto a cycle kind
   function automatic cbc_kind_type decode_kind(input logic [2:0] st);
      cbc_kind_type k;
      k = KD_PASSIVE;
      case (st)
         `CBC_ST_IRQ_ACK:   k = KD_IRQ_ACK;
         `CBC_ST_IO_READ:   k = KD_IO_READ;
         `CBC_ST_IO_WRITE:  k = KD_IO_WRITE;
         `CBC_ST_HALT:      k = KD_HALT;
         `CBC_ST_CODE:      k = KD_MEM_READ;
         `CBC_ST_MEM_READ:  k = KD_MEM_READ;
         `CBC_ST_MEM_WRITE: k = KD_MEM_WRITE;
         default:           k = KD_PASSIVE;
      endcase
      return k;
   endfunction

   // is a kind served on the io side (ack counts as io)
   function automatic logic is_io(input cbc_kind_type k);
      return (k == KD_IRQ_ACK) || (k == KD_IO_READ) || (k == KD_IO_WRITE);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // status and grant

   assign status  = {status_bit2_n, status_bit1_n, status_bit0_n};
   assign passive = (status == `CBC_ST_PASSIVE);
   assign start   = (phase_r == PH_IDLE) && !passive; // RULE_17

   cbc_grant_timer #(
      .DLY_CYC (GRANT_DLY_CYC),
      .CNT_W   (GRANT_CNT_W)
   ) u_grant_timer (
      .ref_clk     (ref_clk),
      .nrst        (nrst),
      .clk_en      (clk_en),
      .bus_grant_n (bus_grant_n),
      .grant_ok    (grant_ok)
   );

   // io in io-bus mode needs no grant, everything else waits for it
   assign io_kind = is_io(kind_r);
   assign allowed = (io_bus_strap && io_kind) ? 1'b1 : grant_ok; // RULE_03 RULE_05 RULE_06 RULE_07
   assign cmd_on  = command_qualifier && allowed && (phase_r inside {PH_EARLY, PH_LATE})
                    && (kind_r != KD_HALT) && (kind_r != KD_PASSIVE) && !passive; // RULE_20

   ////////////////////////////////////////////////////////////////////////////
   // machine-cycle sequencer

   // strobe phase, early phase, then late phase held until status goes passive
   always_comb begin
      phase_nxt = phase_r;
      case (phase_r)
         PH_IDLE:  if (!passive) phase_nxt = PH_ALE;
         PH_ALE:   phase_nxt = passive ? PH_IDLE : PH_EARLY;
         PH_EARLY: phase_nxt = passive ? PH_IDLE : PH_LATE;
         PH_LATE:  if (passive) phase_nxt = PH_IDLE; // RULE_20
         default:  phase_nxt = PH_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         phase_r <= PH_IDLE;
      end else if (clk_en) begin
         phase_r <= phase_nxt;
      end
   end

   // cycle kind captured together with the address strobe
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         kind_r <= KD_PASSIVE;
      end else if (clk_en) begin
         if (start) begin
            kind_r <= decode_kind(status); // RULE_15
         end else if (phase_nxt == PH_IDLE) begin
            kind_r <= KD_PASSIVE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command lines

   // reads, ack and early writes in the early phase; ordinary writes follow
   always_comb begin
      cmd_nxt = `CBC_CMD_IDLE; // RULE_16 RULE_20
      if (cmd_on) begin
         case (kind_r)
            KD_IRQ_ACK:  cmd_nxt.irq_ack_n = 1'b0; // RULE_01 RULE_09
            KD_IO_READ:  cmd_nxt.io_rd_n = 1'b0; // RULE_01 RULE_04
            KD_IO_WRITE: begin
               cmd_nxt.early_io_wr_n = 1'b0; // RULE_01
               cmd_nxt.io_wr_n = !((phase_r == PH_LATE) && !cmd_r.early_io_wr_n); // RULE_08
            end
            KD_MEM_READ: cmd_nxt.mem_rd_n = 1'b0; // RULE_02
            KD_MEM_WRITE: begin
               cmd_nxt.early_mem_wr_n = 1'b0; // RULE_02
               cmd_nxt.mem_wr_n = !((phase_r == PH_LATE) && !cmd_r.early_mem_wr_n); // RULE_08
            end
            default: cmd_nxt = `CBC_CMD_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cmd_r <= `CBC_CMD_IDLE;
      end else if (clk_en) begin
         cmd_r <= cmd_nxt; // RULE_19
      end
   end

   // drivers float while the grant is inactive, io stays driven in io-bus mode
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         mem_oe_n_r <= 1'b1;
         io_oe_n_r  <= 1'b1;
      end else if (clk_en) begin
         mem_oe_n_r <= bus_grant_n; // RULE_18
         io_oe_n_r  <= io_bus_strap ? 1'b0 : bus_grant_n; // RULE_03 RULE_18
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control lines

   // one strobe at the start of every machine cycle
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ale_r <= 1'b0;
      end else if (clk_en) begin
         ale_r <= start; // RULE_15
      end
   end

   // system data enable; io cycles in io-bus mode use the peripheral enable
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         de_r <= 1'b0;
      end else if (clk_en) begin
         de_r <= cmd_on && !(io_bus_strap && io_kind); // RULE_10 RULE_16
      end
   end

   // direction is high through the whole of a write cycle
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dir_r <= 1'b0;
      end else if (clk_en) begin
         if (start) begin
            dir_r <= (status == `CBC_ST_IO_WRITE) || (status == `CBC_ST_MEM_WRITE); // RULE_10
         end else if (phase_nxt == PH_IDLE) begin
            dir_r <= 1'b0; // RULE_19
         end
      end
   end

   // dual pin: active-low peripheral enable or cascade pulse with the strobe
   always_comb begin
      if (io_bus_strap) begin
         dual_nxt = !(cmd_on && io_kind); // RULE_04 RULE_11
      end else begin
         dual_nxt = start && (status == `CBC_ST_IRQ_ACK); // RULE_11 RULE_12 RULE_14
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dual_r <= 1'b0;
      end else if (clk_en) begin
         dual_r <= dual_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign mem_read_cmd_n        = cmd_r.mem_rd_n;
   assign mem_write_cmd_n       = cmd_r.mem_wr_n;
   assign io_read_cmd_n         = cmd_r.io_rd_n;
   assign io_write_cmd_n        = cmd_r.io_wr_n;
   assign early_mem_write_cmd_n = cmd_r.early_mem_wr_n;
   assign early_io_write_cmd_n  = cmd_r.early_io_wr_n;
   assign irq_ack_cmd_n         = cmd_r.irq_ack_n;
   assign mem_cmd_oe_n          = mem_oe_n_r;
   assign io_cmd_oe_n           = io_oe_n_r;
   assign address_latch_strobe  = ale_r;
   assign data_enable           = de_r;
   assign transfer_direction    = dir_r;
   assign cascade_gate_dual     = dual_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   // independent count of cycles with the grant held low
   logic [7:0] grant_low_cnt;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         grant_low_cnt <= 8'h00;
      end else if (clk_en) begin
         if (bus_grant_n) begin
            grant_low_cnt <= 8'h00;
         end else if (grant_low_cnt != 8'hFF) begin
            grant_low_cnt <= grant_low_cnt + 8'h01;
         end
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst || !clk_en);
   io_read_decode_a: assert property ( // RULE_01
      !io_read_cmd_n |-> kind_r == KD_IO_READ && io_write_cmd_n && irq_ack_cmd_n)
      else $error("io read issued for a non io-read cycle");
   mem_read_decode_a: assert property ( // RULE_02
      !mem_read_cmd_n |-> kind_r == KD_MEM_READ && mem_write_cmd_n)
      else $error("memory read issued for a non memory-read cycle");
   iob_io_free_a: assert property ( // RULE_04
      (phase_r == PH_EARLY && kind_r == KD_IO_READ && io_bus_strap
       && command_qualifier && !passive)
      |=> !io_read_cmd_n && !cascade_gate_dual && !io_cmd_oe_n)
      else $error("io-bus io read not issued at once");
   mem_wait_grant_a: assert property ( // RULE_05
      $fell(mem_read_cmd_n) |-> $past(grant_low_cnt) >= 8'(GRANT_DLY_CYC))
      else $error("memory read issued before grant delay");
   sys_grant_delay_a: assert property ( // RULE_06
      (!io_bus_strap && !$past(io_bus_strap) && $fell(io_read_cmd_n))
      |-> $past(grant_low_cnt) >= 8'(GRANT_DLY_CYC))
      else $error("system-bus io read before grant delay");
   early_write_lead_a: assert property ( // RULE_08
      $fell(mem_write_cmd_n) |-> !early_mem_write_cmd_n && !$past(early_mem_write_cmd_n))
      else $error("memory write without preceding early write");
   cascade_pulse_a: assert property ( // RULE_14
      (!io_bus_strap && start && status == `CBC_ST_IRQ_ACK)
      |=> cascade_gate_dual && address_latch_strobe ##1 !cascade_gate_dual)
      else $error("cascade enable not pulsed with ack strobe");
   strobe_once_a: assert property ( // RULE_15
      start |=> address_latch_strobe ##1 !address_latch_strobe)
      else $error("address strobe not one pulse per cycle");
   qualifier_off_a: assert property ( // RULE_16
      !command_qualifier |=> cmd_r == `CBC_CMD_IDLE && !data_enable)
      else $error("command active while qualifier low");
   grant_float_a: assert property ( // RULE_18
      (bus_grant_n && !io_bus_strap) |=> mem_cmd_oe_n && io_cmd_oe_n)
      else $error("drivers enabled while grant inactive");
   write_dir_a: assert property ( // RULE_19
      !mem_write_cmd_n || !io_write_cmd_n |-> transfer_direction)
      else $error("write command with receive direction");
   passive_release_a: assert property ( // RULE_20
      (phase_r != PH_IDLE && passive) |=> cmd_r == `CBC_CMD_IDLE && !data_enable)
      else $error("command not released on passive status");
   mem_write_c: cover property (
      $fell(early_mem_write_cmd_n) ##1 $fell(mem_write_cmd_n));
   iob_io_read_c: cover property (
      io_bus_strap && bus_grant_n && $fell(io_read_cmd_n));
   irq_pair_c: cover property (
      !io_bus_strap && $fell(irq_ack_cmd_n) ##[2:40] $fell(irq_ack_cmd_n));

endmodule
`default_nettype wire

// file: hdl/cbc_grant_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "cbc_regs.svh"

module cbc_grant_timer #(
   parameter int unsigned DLY_CYC = `CBC_GRANT_DLY_CYC,
   parameter int unsigned CNT_W   = 4
) (
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic clk_en,
   input  wire logic bus_grant_n,
   output logic      grant_ok
);

   logic [CNT_W-1:0] cnt_r;

   // count clock edges since the grant went low, saturating at the delay
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= '0;
      end else if (clk_en) begin
         if (bus_grant_n) begin
            cnt_r <= '0;
         end else if (cnt_r != CNT_W'(DLY_CYC)) begin
            cnt_r <= cnt_r + CNT_W'(1);
         end
      end
   end

   // grant is usable once the full delay has passed with grant held low
   assign grant_ok = !bus_grant_n && (cnt_r == CNT_W'(DLY_CYC));

endmodule
`default_nettype wire

// file: hdl/cbc_pkg.sv
package cbc_pkg;

   // kind of machine cycle latched from the status lines
   typedef enum logic [2:0] {
      KD_IRQ_ACK,
      KD_IO_READ,
      KD_IO_WRITE,
      KD_HALT,
      KD_MEM_READ,
      KD_MEM_WRITE,
      KD_PASSIVE
   } cbc_kind_type;

   // position inside one machine cycle
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_ALE,
      PH_EARLY,
      PH_LATE
   } cbc_phase_type;

   // the seven command lines, all active low
   typedef struct packed {
      logic mem_rd_n;
      logic mem_wr_n;
      logic io_rd_n;
      logic io_wr_n;
      logic early_mem_wr_n;
      logic early_io_wr_n;
      logic irq_ack_n;
   } cbc_cmd_type;

endpackage

// file: hdl/cbc_regs.svh
`ifndef CBC_REGS_SVH
`define CBC_REGS_SVH

// status codes, written as {s2_n, s1_n, s0_n}
`define CBC_ST_IRQ_ACK   3'h0
`define CBC_ST_IO_READ   3'h1
`define CBC_ST_IO_WRITE  3'h2
`define CBC_ST_HALT      3'h3
`define CBC_ST_CODE      3'h4
`define CBC_ST_MEM_READ  3'h5
`define CBC_ST_MEM_WRITE 3'h6
`define CBC_ST_PASSIVE   3'h7

// command group with every active-low line released
`define CBC_CMD_IDLE     7'h7F

// timing: clock period and the grant-to-command delay
`define CBC_CLK_PERIOD_NS 10
`define CBC_GRANT_DLY_NS  115
`define CBC_GRANT_DLY_CYC \
   ((`CBC_GRANT_DLY_NS + `CBC_CLK_PERIOD_NS - 1) / `CBC_CLK_PERIOD_NS)

`endif

// file: sim/cbc_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// processor status lines and bus arbiter seen from the command decoder
module cbc_cpu_model (
   input  wire logic ref_clk,
   output logic      status_bit0_n,
   output logic      status_bit1_n,
   output logic      status_bit2_n,
   output logic      bus_grant_n
);
   logic [2:0] status_r  = 3'h7; // idle processor parks on passive
   logic       grant_n_r = 1'h1; // arbiter starts with the bus taken

   // status code is {bit2, bit1, bit0}, all ones between cycles
   assign {status_bit2_n, status_bit1_n, status_bit0_n} = status_r;
   assign bus_grant_n = grant_n_r;

   // open a machine cycle with a non-passive code
   task automatic start_cycle(input logic [2:0] code);
      @(posedge ref_clk);
      status_r <= code;
   endtask

   // close the cycle by returning to passive
   task automatic end_cycle();
      @(posedge ref_clk);
      status_r <= 3'h7;
   endtask

   // arbiter answer, then held for some edges so the grant has settled
   task automatic set_grant(input logic free_n, input int settle);
      @(posedge ref_clk);
      grant_n_r <= free_n;
      repeat (settle) @(posedge ref_clk);
   endtask
endmodule

`default_nettype wire

// file: sim/cpu_status_bus_command_decoder_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module cpu_status_bus_command_decoder_tb_top;
   import cbc_pkg::*;
   localparam int unsigned DLY = 4; // short grant delay for quick runs

   logic        ref_clk = 1'h0;
   logic        nrst = 1'h0;
   logic        command_qualifier = 1'h1;
   logic        io_bus_strap = 1'h0;
   logic        s0_n, s1_n, s2_n, grant_n;
   logic        mrd_n, mwr_n, iord_n, iowr_n, emw_n, eiow_n, ack_n;
   logic        mem_oe_n, io_oe_n, strobe, data_en, dir, dual;
   cbc_cmd_type cmd;
   int          errors = 0;
   int          total_checks = 0;

   // command group in package order
   assign cmd = {mrd_n, mwr_n, iord_n, iowr_n, emw_n, eiow_n, ack_n};

   // clock at 100 MHz
   always #5 ref_clk = ~ref_clk;

   cbc_cpu_model i_cpu (
      .ref_clk       (ref_clk),
      .status_bit0_n (s0_n),
      .status_bit1_n (s1_n),
      .status_bit2_n (s2_n),
      .bus_grant_n   (grant_n)
   );

   cbc_decoder #(.GRANT_DLY_CYC(DLY), .GRANT_CNT_W(4)) i_dut (
      .ref_clk               (ref_clk),
      .nrst                  (nrst),
      .clk_en                (1'h1),
      .status_bit0_n         (s0_n),
      .status_bit1_n         (s1_n),
      .status_bit2_n         (s2_n),
      .bus_grant_n           (grant_n),
      .command_qualifier     (command_qualifier),
      .io_bus_strap          (io_bus_strap),
      .mem_read_cmd_n        (mrd_n),
      .mem_write_cmd_n       (mwr_n),
      .io_read_cmd_n         (iord_n),
      .io_write_cmd_n        (iowr_n),
      .early_mem_write_cmd_n (emw_n),
      .early_io_write_cmd_n  (eiow_n),
      .irq_ack_cmd_n         (ack_n),
      .mem_cmd_oe_n          (mem_oe_n),
      .io_cmd_oe_n           (io_oe_n),
      .address_latch_strobe  (strobe),
      .data_enable           (data_en),
      .transfer_direction    (dir),
      .cascade_gate_dual     (dual)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // comparison and end of run
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // one machine cycle: strobe, early phase, late phase, release
   task automatic run_cyc(input logic [2:0] code, input logic [6:0] e3, input logic [6:0] e4,
                          input logic eden, input logic edual);
      int n;
      i_cpu.start_cycle(code);
      n = 0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (strobe !== 1'h1 && n < 6);
      chk("strobe", 8'h01, {7'h00, strobe});
      chk("direction", {7'h00, code[1] & ~code[0]}, {7'h00, dir});
      if (!io_bus_strap) chk("cascade", {7'h00, code == 3'h0}, {7'h00, dual});
      repeat (2) begin
         @(posedge ref_clk);
         #1;
      end
      chk("strobe once", 8'h00, {7'h00, strobe});
      chk("cmd early", {1'h0, e3}, {1'h0, cmd});
      chk("data enable", {7'h00, eden}, {7'h00, data_en});
      if (io_bus_strap) chk("periph enable", {7'h00, edual}, {7'h00, dual});
      @(posedge ref_clk);
      #1;
      chk("cmd late", {1'h0, e4}, {1'h0, cmd});
      i_cpu.end_cycle();
      n = 0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (cmd !== 7'h7F && n < 4);
      chk("cmd off", 8'h7F, {1'h0, cmd});
      chk("data enable off", 8'h00, {7'h00, data_en});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_decode();
      logic [6:0] e3 [7] = '{7'h7E, 7'h6F, 7'h7D, 7'h7F, 7'h3F, 7'h3F, 7'h7B};
      logic [6:0] e4 [7] = '{7'h7E, 7'h6F, 7'h75, 7'h7F, 7'h3F, 7'h3F, 7'h5B};
      i_cpu.set_grant(1'h0, DLY + 2);
      for (int i = 0; i < 7; i++) run_cyc(i[2:0], e3[i], e4[i], i != 3, 1'h0);
      repeat (4) begin
         @(posedge ref_clk);
         #1;
         chk("passive strobe", 8'h00, {7'h00, strobe});
      end
      $display("test decode done");
   endtask

   task automatic t_ack_pair();
      // first ack moves nothing: outside logic masks its cascade pulse
      run_cyc(3'h0, 7'h7E, 7'h7E, 1'h1, 1'h0);
      run_cyc(3'h0, 7'h7E, 7'h7E, 1'h1, 1'h0);
      $display("test ack pair done");
   endtask

   task automatic t_grant_wait();
      int n;
      i_cpu.set_grant(1'h1, 0);
      repeat (3) @(posedge ref_clk);
      #1;
      chk("mem float", 8'h01, {7'h00, mem_oe_n});
      chk("io float", 8'h01, {7'h00, io_oe_n});
      i_cpu.set_grant(1'h0, 0);
      i_cpu.start_cycle(3'h1);
      n = 1;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (iord_n !== 1'h0 && n < DLY + 8);
      chk("no early cmd", 8'h01, {7'h00, n > DLY});
      chk("cmd in time", 8'h00, {7'h00, iord_n});
      i_cpu.end_cycle();
      repeat (4) @(posedge ref_clk);
      $display("test grant wait done");
   endtask

   task automatic t_io_bus();
      @(posedge ref_clk);
      io_bus_strap <= 1'h1;
      i_cpu.set_grant(1'h1, 1);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("mem float", 8'h01, {7'h00, mem_oe_n});
      chk("io driven", 8'h00, {7'h00, io_oe_n});
      run_cyc(3'h1, 7'h6F, 7'h6F, 1'h0, 1'h0);
      chk("periph off", 8'h01, {7'h00, dual});
      run_cyc(3'h2, 7'h7D, 7'h75, 1'h0, 1'h0);
      run_cyc(3'h5, 7'h7F, 7'h7F, 1'h0, 1'h1);
      i_cpu.set_grant(1'h0, DLY + 2);
      run_cyc(3'h5, 7'h3F, 7'h3F, 1'h1, 1'h1);
      @(posedge ref_clk);
      io_bus_strap <= 1'h0;
      $display("test io bus done");
   endtask

   task automatic t_qualifier();
      @(posedge ref_clk);
      command_qualifier <= 1'h0;
      run_cyc(3'h5, 7'h7F, 7'h7F, 1'h0, 1'h0);
      run_cyc(3'h6, 7'h7F, 7'h7F, 1'h0, 1'h0);
      @(posedge ref_clk);
      command_qualifier <= 1'h1;
      run_cyc(3'h6, 7'h7B, 7'h5B, 1'h1, 1'h0);
      $display("test qualifier done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence: reset for 2 cycles, then the scenarios
   initial begin
      #6;
      chk("reset cmd", 8'h7F, {1'h0, cmd});
      chk("reset ctl", 8'h03, {4'h0, strobe, data_en, mem_oe_n, io_oe_n});
      repeat (2) @(posedge ref_clk);
      nrst <= 1'h1;
      t_decode();
      t_ack_pair();
      t_qualifier();
      t_grant_wait();
      t_io_bus();
      complete_run();
   end

   // watchdog against a hung handshake
   initial begin
      repeat (5000) @(posedge ref_clk);
      errors++;
      complete_run();
   end
endmodule

`default_nettype wire
